// ---- rtl/ctm_cfg.svh ----
// Register offsets, field positions, reset values and timing counts of the capture timer
`ifndef CTM_CFG_SVH
`define CTM_CFG_SVH
`define CTM_OFS_COUNT      6'h00
`define CTM_OFS_CC_FIRST   6'h04
`define CTM_OFS_CC_SECOND  6'h08
`define CTM_OFS_MODE       6'h0c
`define CTM_OFS_CAPCTL     6'h10
`define CTM_OFS_PRESC      6'h14
`define CTM_OFS_IRQ_STAT   6'h18
`define CTM_OFS_IRQ_CLR    6'h1c
`define CTM_OFS_IRQ_EN     6'h20
`define CTM_MODE_OVF_BIT   0
`define CTM_MODE_OS_BIT    4
`define CTM_CAP_FIRST_BIT  0
`define CTM_CAP_SRC_BIT    1
`define CTM_CAP_SECOND_BIT 2
`define CTM_IRQ_FIRST_BIT  0
`define CTM_IRQ_SECOND_BIT 1
`define CTM_IRQ_OVF_BIT    2
`define CTM_RST_CC         16'h0000
`define CTM_RST_PRESC      8'h00
`define CTM_CNT_MAX        16'hffff
`define CTM_DIV_LOG2_A     2
`define CTM_DIV_LOG2_B     4
`define CTM_CAP_IRQ_WAIT   20
`endif

// ---- rtl/ctm_edge_filt.sv ----
// Noise filter and edge classifier for one edge input
module ctm_edge_filt (
   // Clock and reset
   input wire logic   sys_clk,
   input wire logic   rst_n,
   // Core side
   ctm_edge_if.filt   port
);
   import ctm_pkg::*;
   logic smp_r;
   logic filt_r;
   logic seen_run_r;
   logic valid_r;
   logic reverse_r;
   logic stable;
   logic change;
   logic rise;

   // A level counts only when it matches the previous sample
   assign stable = port.sample_en && (port.lvl == smp_r);
   assign change = stable && (port.lvl != filt_r);
   assign rise   = port.lvl;

   // Sample register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         smp_r <= 1'b0;
      end else if (port.sample_en) begin
         smp_r <= port.lvl;
      end
   end

   // first enable edge
   // Filtered level stays low until the first run, so a high input then reads as a rise
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_run_r <= 1'b0;
         filt_r     <= 1'b0;
      end else begin
         if (port.run) begin
            seen_run_r <= 1'b1;
         end
         if (stable && (port.run || seen_run_r)) begin
            filt_r <= port.lvl;
         end
      end
   end

   // ignored while stopped
   // Edge strobes are classified against the selected polarity
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_r   <= 1'b0;
         reverse_r <= 1'b0;
      end else begin
         valid_r   <= 1'b0;
         reverse_r <= 1'b0;
         if (change && port.run) begin
            case (port.edge_sel)
               CTM_EDGE_FALL: begin
                  valid_r   <= !rise;
                  reverse_r <= rise;
               end
               CTM_EDGE_RISE: begin
                  valid_r   <= rise;
                  reverse_r <= !rise;
               end
               CTM_EDGE_BOTH: begin
                  valid_r   <= 1'b1;
               end
               default: begin
                  valid_r   <= 1'b0;
               end
            endcase
         end
      end
   end

   assign port.valid_edge   = valid_r;
   assign port.reverse_edge = reverse_r;

   chk_stop_no_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !port.run |=> !valid_r && !reverse_r) else $error("edge strobe while timer stopped");
   chk_two_samples: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (port.sample_en && port.lvl != smp_r) |=> filt_r == $past(filt_r))
      else $error("filtered level followed a single sample");
endmodule

// ---- rtl/ctm_edge_if.sv ----
// Signals between the timer core and one edge input filter
interface ctm_edge_if;
   import ctm_pkg::*;
   logic      lvl;
   logic      sample_en;
   logic      run;
   ctm_edge_t edge_sel;
   logic      valid_edge;
   logic      reverse_edge;
   modport filt (input lvl, sample_en, run, edge_sel, output valid_edge, reverse_edge);
   modport core (output lvl, sample_en, run, edge_sel, input valid_edge, reverse_edge);
endinterface

// ---- rtl/ctm_pkg.sv ----
// Types shared by the capture timer modules
package ctm_pkg;
   typedef enum logic [1:0] {
      CTM_STOP      = 2'b00,
      CTM_FREE      = 2'b01,
      CTM_CLR_EDGE  = 2'b10,
      CTM_CLR_MATCH = 2'b11
   } ctm_mode_t;
   typedef enum logic [1:0] {
      CTM_EDGE_FALL = 2'b00,
      CTM_EDGE_RISE = 2'b01,
      CTM_EDGE_NONE = 2'b10,
      CTM_EDGE_BOTH = 2'b11
   } ctm_edge_t;
   typedef enum logic [1:0] {
      CTM_PRE_DIV1  = 2'b00,
      CTM_PRE_DIVA  = 2'b01,
      CTM_PRE_DIVB  = 2'b10,
      CTM_PRE_EXT   = 2'b11
   } ctm_presc_t;
endpackage

// ---- rtl/ctm_presc.sv ----
// Count clock generator: free-running divider or external event strobe
`include "ctm_cfg.svh"
module ctm_presc #(
   parameter int DIV_A = `CTM_DIV_LOG2_A,
   parameter int DIV_B = `CTM_DIV_LOG2_B
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   // Selection and strobes
   input  wire ctm_pkg::ctm_presc_t sel,
   input  wire logic              ext_tick,
   output logic                   tick
);
   import ctm_pkg::*;
   logic [DIV_B-1:0] div_r;

   // start not aligned
   // Divider never resets on timer start, so the first tick lands anywhere in a period
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   // Tick selection
   always_comb begin
      case (sel)
         CTM_PRE_DIV1: tick = 1'b1;
         CTM_PRE_DIVA: tick = (div_r[DIV_A-1:0] == '1);
         CTM_PRE_DIVB: tick = (div_r == '1);
         default:      tick = ext_tick;
      endcase
   end

   chk_div_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sel == CTM_PRE_DIV1 |-> tick) else $error("no tick at divide by one");
endmodule

// ---- rtl/ctm_timer.sv ----
// 16-bit timer/event counter with two capture/compare registers and an Avalon-MM slave
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`include "ctm_cfg.svh"

// Overview of operation
// - First match may slip one count clock
// - Capture proceeds during read; reverse edge silent
// - Capture contents undefined after stop
// - Overflow flag on wrap or FFFF match
// - Clear ignored until counter leaves zero
// - One-shot only free-run or edge-clear
// - Input-as-count-clock disables its capture
// - Capture now, interrupt at next tick
// - Source bit: reverse capture, external interrupt
// - First enable treats high as rise
// - Filter clock depends on input use
// - Two equal samples make an edge
// - Inputs ignored while timer stopped
// - Mode codes stop, free, edge-clear, match-clear
module ctm_timer (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Avalon-MM slave
   input  wire logic [5:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Edge inputs
   input  wire logic        edge_input_first,
   input  wire logic        edge_input_second,
   // Events and outputs
   output logic             first_event_irq,
   output logic             second_event_irq,
   output logic             irq,
   output logic             oneshot_out
);
   import ctm_pkg::*;

   logic [15:0] main_counter_r;
   logic [15:0] capture_compare_first_r;
   logic [15:0] capture_compare_second_r;
   ctm_mode_t   op_mode_r;
   logic        overflow_flag_r;
   logic        ovf_hold_r;
   logic        oneshot_en_r;
   logic        first_capture_r;
   logic        second_capture_r;
   logic        capture_source_select_r;
   ctm_presc_t  prescaler_select_r;
   ctm_edge_t   edge_sel_first_r;
   ctm_edge_t   edge_sel_second_r;
   logic [2:0]  irq_stat_r;
   logic [2:0]  irq_en_r;
   logic        ack_r;
   logic        pend_first_r;
   logic        pend_second_r;
   logic        first_irq_r;
   logic        second_irq_r;
   logic        os_active_r;

   logic        run;
   logic        tick;
   logic        wr_fire;
   logic        e1v;
   logic        e1r;
   logic        e2v;
   logic        clr_edge;
   logic        ovf_ev;
   logic        match_first;
   logic        match_second;
   logic        cap_first;
   logic        cap_first_irq;
   logic        cap_second;
   logic        ext_first;
   logic        ext_count;
   logic [2:0]  ev_vec;
   logic [31:0] rd_nxt;

   ctm_edge_if eif [2] ();

   assign run       = (op_mode_r != CTM_STOP);
   assign ext_count = (prescaler_select_r == CTM_PRE_EXT);

   // Edge filter channels; first channel feeds both counting and capture
   assign eif[0].lvl      = edge_input_first;
   assign eif[1].lvl      = edge_input_second;
   assign eif[0].run      = run;
   assign eif[1].run      = run;
   assign eif[0].edge_sel = edge_sel_first_r;
   assign eif[1].edge_sel = edge_sel_second_r;
   assign eif[0].sample_en = ext_count ? 1'b1 : tick;
   assign eif[1].sample_en = tick;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_filt
         ctm_edge_filt u_filt (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .port    (eif[g])
         );
      end
   endgenerate

   assign e1v = eif[0].valid_edge;
   assign e1r = eif[0].reverse_edge;
   assign e2v = eif[1].valid_edge;

   // Count clock source; external counting uses the first input's valid edge
   ctm_presc u_presc (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .sel      (prescaler_select_r),
      .ext_tick (e1v),
      .tick     (tick)
   );

   // Event decode
   // edge-clear mode
   assign clr_edge     = (op_mode_r == CTM_CLR_EDGE) && e1v && !ext_count;
   assign ovf_ev       = run && tick && !clr_edge && (main_counter_r == `CTM_CNT_MAX);
   assign match_first  = run && tick && !first_capture_r && (main_counter_r == capture_compare_first_r);
   assign match_second = run && tick && !second_capture_r && (main_counter_r == capture_compare_second_r);
   assign cap_first    = first_capture_r &&
                         (capture_source_select_r ? (e1r && !ext_count) : e2v);
   assign cap_second   = second_capture_r && e1v && !ext_count;
   assign cap_first_irq = cap_first && !capture_source_select_r;
   assign ext_first     = first_capture_r && capture_source_select_r && e2v;

   // Bus handshake: one wait cycle, write lands on the released edge
   assign waitrequest = (read || write) && !ack_r;
   assign wr_fire     = write && ack_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (read || write) && !ack_r;
      end
   end

   // Main counter
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         main_counter_r <= 16'h0000;
      end else if (!run || clr_edge) begin
         main_counter_r <= 16'h0000;
      end else if (tick) begin
         if (op_mode_r == CTM_CLR_MATCH && main_counter_r == capture_compare_first_r) begin
            main_counter_r <= 16'h0000;
         end else begin
            main_counter_r <= main_counter_r + 16'h0001;
         end
      end
   end

   // First capture/compare; capture wins over a simultaneous software write
   // capture during read
   // values not kept meaningful after stop, no clean-up is done
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         capture_compare_first_r <= `CTM_RST_CC;
      end else if (cap_first) begin
         capture_compare_first_r <= main_counter_r;
      end else if (wr_fire && address == `CTM_OFS_CC_FIRST) begin
         capture_compare_first_r <= writedata[15:0];
      end
   end

   // Second capture/compare
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         capture_compare_second_r <= `CTM_RST_CC;
      end else if (cap_second) begin
         capture_compare_second_r <= main_counter_r;
      end else if (wr_fire && address == `CTM_OFS_CC_SECOND) begin
         capture_compare_second_r <= writedata[15:0];
      end
   end

   // Control registers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_mode_r               <= CTM_STOP;
         oneshot_en_r            <= 1'b0;
         first_capture_r         <= 1'b0;
         second_capture_r        <= 1'b0;
         capture_source_select_r <= 1'b0;
         prescaler_select_r      <= CTM_PRE_DIV1;
         edge_sel_first_r        <= CTM_EDGE_FALL;
         edge_sel_second_r       <= CTM_EDGE_FALL;
         irq_en_r                <= 3'h0;
      end else if (wr_fire) begin
         case (address)
            `CTM_OFS_MODE: begin
               op_mode_r    <= ctm_mode_t'(writedata[3:2]);
               oneshot_en_r <= writedata[`CTM_MODE_OS_BIT];
            end
            `CTM_OFS_CAPCTL: begin
               first_capture_r         <= writedata[`CTM_CAP_FIRST_BIT];
               capture_source_select_r <= writedata[`CTM_CAP_SRC_BIT];
               second_capture_r        <= writedata[`CTM_CAP_SECOND_BIT];
            end
            `CTM_OFS_PRESC: begin
               prescaler_select_r <= ctm_presc_t'(writedata[1:0]);
               if (!run) begin
                  edge_sel_first_r  <= ctm_edge_t'(writedata[5:4]);
                  edge_sel_second_r <= ctm_edge_t'(writedata[7:6]);
               end
            end
            `CTM_OFS_IRQ_EN: begin
               irq_en_r <= writedata[2:0];
            end
            default: begin
               irq_en_r <= irq_en_r;
            end
         endcase
      end
   end

   // Overflow flag; hold window lasts until the counter moves on from zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_hold_r <= 1'b0;
      end else if (ovf_ev) begin
         ovf_hold_r <= 1'b1;
      end else if (tick || !run) begin
         ovf_hold_r <= 1'b0;
      end
   end

   // clear ignored early
   // Software clear by writing zero; set and hold window both win over it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag_r <= 1'b0;
      end else if (ovf_ev || ovf_hold_r) begin
         overflow_flag_r <= overflow_flag_r | ovf_ev;
      end else if (wr_fire && address == `CTM_OFS_MODE && !writedata[`CTM_MODE_OVF_BIT]) begin
         overflow_flag_r <= 1'b0;
      end
   end

   // interrupt at next tick
   // Captured value lands at once, its interrupt waits for the following count tick
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_first_r  <= 1'b0;
         pend_second_r <= 1'b0;
      end else if (!run) begin
         pend_first_r  <= 1'b0;
         pend_second_r <= 1'b0;
      end else begin
         pend_first_r  <= cap_first_irq || (pend_first_r && !tick);
         pend_second_r <= cap_second || (pend_second_r && !tick);
      end
   end

   // Event pulses
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         first_irq_r  <= 1'b0;
         second_irq_r <= 1'b0;
      end else begin
         first_irq_r  <= match_first || (pend_first_r && tick) || ext_first;
         second_irq_r <= match_second || (pend_second_r && tick);
      end
   end

   assign first_event_irq  = first_irq_r;
   assign second_event_irq = second_irq_r;
   assign ev_vec = {ovf_ev, second_irq_r, first_irq_r};

   // Sticky status; an event in the clearing cycle survives
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= 3'h0;
      end else if (wr_fire && address == `CTM_OFS_IRQ_CLR) begin
         irq_stat_r <= (irq_stat_r & ~writedata[2:0]) | ev_vec;
      end else begin
         irq_stat_r <= irq_stat_r | ev_vec;
      end
   end

   assign irq = |(irq_stat_r & irq_en_r);

   // One-shot pulse: starts on first-input valid edge, ends on first compare match
   // no one-shot in match-clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         os_active_r <= 1'b0;
      end else if (!oneshot_en_r || !run || op_mode_r == CTM_CLR_MATCH) begin
         os_active_r <= 1'b0;
      end else if (os_active_r) begin
         if (tick && main_counter_r == capture_compare_first_r) begin
            os_active_r <= 1'b0;
         end
      end else if (e1v && !ext_count) begin
         os_active_r <= 1'b1;
      end
   end

   assign oneshot_out = os_active_r;

   // Read mux; unmapped and write-only offsets read as zero
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (address)
         `CTM_OFS_COUNT:     rd_nxt[15:0] = main_counter_r;
         `CTM_OFS_CC_FIRST:  rd_nxt[15:0] = capture_compare_first_r;
         `CTM_OFS_CC_SECOND: rd_nxt[15:0] = capture_compare_second_r;
         `CTM_OFS_MODE:      rd_nxt[4:0]  = {oneshot_en_r, op_mode_r, 1'b0, overflow_flag_r};
         `CTM_OFS_CAPCTL:    rd_nxt[2:0]  = {second_capture_r, capture_source_select_r, first_capture_r};
         `CTM_OFS_PRESC:     rd_nxt[7:0]  = {edge_sel_second_r, edge_sel_first_r, 2'b00, prescaler_select_r};
         `CTM_OFS_IRQ_STAT:  rd_nxt[2:0]  = irq_stat_r;
         `CTM_OFS_IRQ_EN:    rd_nxt[2:0]  = irq_en_r;
         default:            rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= 32'h0000_0000;
      end else if (read && !ack_r) begin
         readdata <= rd_nxt;
      end
   end

   // Checks
   localparam int CAP_WAIT = `CTM_CAP_IRQ_WAIT;

   // External counting has no time bound on the next tick, so it is left out
   sequence s_cap_taken;
      cap_first_irq && run && !ext_count;
   endsequence
   sequence s_irq_follows;
      ##[1:CAP_WAIT] first_event_irq;
   endsequence

   chk_ovf_set_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ovf_ev |=> overflow_flag_r) else $error("overflow did not set flag");
   chk_ovf_clear_void: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ovf_hold_r && overflow_flag_r) |=> overflow_flag_r) else $error("flag cleared in hold window");
   chk_cap_irq_next: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_cap_taken |-> s_irq_follows) else $error("capture interrupt missing");
   chk_cap_value_taken: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cap_second |=> capture_compare_second_r == $past(main_counter_r)) else $error("capture value wrong");
   chk_reverse_no_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (capture_source_select_r && !pend_first_r && !match_first && !ext_first) |=> !first_event_irq)
      else $error("interrupt on reverse-phase capture");
   chk_oneshot_mode_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
      op_mode_r == CTM_CLR_MATCH |=> !oneshot_out) else $error("one-shot in match-clear mode");
   chk_edge_clear_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clr_edge |=> main_counter_r == 16'h0000) else $error("edge did not clear counter");
   chk_count_input_cap: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ext_count && e1v) |=> capture_compare_second_r == $past(capture_compare_second_r) || $past(wr_fire))
      else $error("capture on count-clock input");
endmodule

// ---- test/ctm_pulse_src.sv ----
// External pulse source model driving both edge inputs of the capture timer
module ctm_pulse_src (
   // Clock
   input  wire logic sys_clk,
   // Edge outputs
   output logic      lvl_first,
   output logic      lvl_second
);
   timeunit 1ns;
   timeprecision 1ps;

   // Both lines idle low, as a pulled-down source would leave them
   initial begin
      lvl_first = 1'b0;
      lvl_second = 1'b0;
   end

   // trigger pulse width
   // Widths of two ticks or more are reliable; a width of one is a deliberate glitch
   task automatic pulse(input bit sel, input int width);
      @(posedge sys_clk);
      if (sel) lvl_second <= 1'b1;
      else lvl_first <= 1'b1;
      repeat (width) @(posedge sys_clk);
      if (sel) lvl_second <= 1'b0;
      else lvl_first <= 1'b0;
   endtask
endmodule

// ---- test/ctm_timer_bench.sv ----
// Self-checking bench for the capture timer over its Avalon-MM slave
`include "ctm_cfg.svh"
module ctm_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        sys_clk, rst_n, read, write, waitrequest, in_first, in_second;
   logic        first_event_irq, second_event_irq, irq, os_out;
   logic [5:0]  address;
   logic [31:0] writedata, readdata, rd_val, cap;
   int          fail_count, cmp_count, cyc, n, n1, n2;
   logic [5:0]  ofs [10] = '{`CTM_OFS_COUNT, `CTM_OFS_CC_FIRST, `CTM_OFS_CC_SECOND, `CTM_OFS_MODE,
                             `CTM_OFS_CAPCTL, `CTM_OFS_PRESC, `CTM_OFS_IRQ_STAT, `CTM_OFS_IRQ_CLR,
                             `CTM_OFS_IRQ_EN, 6'h24};

   ctm_timer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
                  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
                  .edge_input_first(in_first), .edge_input_second(in_second),
                  .first_event_irq(first_event_irq), .second_event_irq(second_event_irq),
                  .irq(irq), .oneshot_out(os_out));
   ctm_pulse_src src (.sys_clk(sys_clk), .lvl_first(in_first), .lvl_second(in_second));

   // Clock at 125 MHz
   initial sys_clk = 1'b0;
   always #4 sys_clk = ~sys_clk;

   // Event pulse counters and run-time ceiling; the overflow wait alone takes about 66000 cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (first_event_irq === 1'b1) n1 <= n1 + 1;
      if (second_event_irq === 1'b1) n2 <= n2 + 1;
      if (cyc == 90000) begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One Avalon access; request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do begin
         @(posedge sys_clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 50);
      if (k >= 50) fail_count++;
      rd_val = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string name);
      bus(1'b0, a, 32'h0);
      chk(name, exp, rd_val);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 6'h00;
      writedata = 32'h0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      // Reset values; the clear register reads zero, and an unmapped place reads zero even after a write
      wr(6'h24, 32'hffffffff);
      for (int i = 0; i < 10; i++) rd(ofs[i], 32'h0, "reset value");
      // First input's rising edge captures into the second register at div1, all interrupts enabled
      wr(`CTM_OFS_PRESC, 32'h50);
      wr(`CTM_OFS_CAPCTL, 32'h4);
      wr(`CTM_OFS_IRQ_EN, 32'h7);
      // Compare value far away so no match pulse mixes into the capture counts
      wr(`CTM_OFS_CC_FIRST, 32'hffff);
      src.pulse(1'b0, 6);
      repeat (4) @(posedge sys_clk);
      rd(`CTM_OFS_IRQ_STAT, 32'h0, "status while stopped");
      wr(`CTM_OFS_MODE, 32'h4);
      wr(`CTM_OFS_PRESC, 32'h0);
      rd(`CTM_OFS_PRESC, 32'h50, "edge select kept");
      // A one-cycle glitch must not pass the two-sample filter
      src.pulse(1'b0, 1);
      repeat (6) @(posedge sys_clk);
      chk("glitch events", 0, n2);
      src.pulse(1'b0, 6);
      repeat (6) @(posedge sys_clk);
      chk("capture events", 1, n2);
      rd(`CTM_OFS_IRQ_STAT, 32'h2, "capture status");
      chk("irq level", 1, irq);
      // Capture is read only after its interrupt, and must lie behind the running count
      bus(1'b0, `CTM_OFS_CC_SECOND, 32'h0);
      cap = rd_val;
      bus(1'b0, `CTM_OFS_COUNT, 32'h0);
      chk("capture below count", 1, (cap != 0 && cap < rd_val));
      wr(`CTM_OFS_IRQ_CLR, 32'h2);
      rd(`CTM_OFS_IRQ_STAT, 32'h0, "status cleared");
      chk("irq released", 0, irq);
      // Source bit set: second input raises the first interrupt without capturing
      wr(`CTM_OFS_MODE, 32'h0);
      wr(`CTM_OFS_CAPCTL, 32'h3);
      wr(`CTM_OFS_CC_FIRST, 32'h1234);
      wr(`CTM_OFS_MODE, 32'h4);
      src.pulse(1'b1, 6);
      repeat (6) @(posedge sys_clk);
      chk("external event", 1, n1);
      rd(`CTM_OFS_CC_FIRST, 32'h1234, "no capture on source bit");
      // Source bit clear: second input captures into the first register, interrupt follows
      wr(`CTM_OFS_CAPCTL, 32'h1);
      src.pulse(1'b1, 6);
      repeat (6) @(posedge sys_clk);
      chk("first capture event", 2, n1);
      bus(1'b0, `CTM_OFS_CC_FIRST, 32'h0);
      chk("first captured", 1, (rd_val != 32'h1234 && rd_val != 0));
      // One-shot in free-run: starts on the first input's edge, ends at the first compare match
      wr(`CTM_OFS_MODE, 32'h0);
      wr(`CTM_OFS_CAPCTL, 32'h0);
      wr(`CTM_OFS_CC_FIRST, 32'h400);
      wr(`CTM_OFS_MODE, 32'h14);
      src.pulse(1'b0, 6);
      repeat (4) @(posedge sys_clk);
      chk("one-shot active", 1, os_out);
      repeat (1100) @(posedge sys_clk);
      chk("one-shot ended", 0, os_out);
      // Clear on match at FFFF sets the overflow flag; only its status is enabled
      wr(`CTM_OFS_MODE, 32'h0);
      wr(`CTM_OFS_CAPCTL, 32'h0);
      wr(`CTM_OFS_IRQ_EN, 32'h4);
      wr(`CTM_OFS_IRQ_CLR, 32'h7);
      wr(`CTM_OFS_CC_FIRST, 32'hffff);
      wr(`CTM_OFS_CC_SECOND, 32'hffff);
      wr(`CTM_OFS_MODE, 32'hc);
      for (n = 0; n < 70000 && irq !== 1'b1; n++) @(negedge sys_clk);
      @(posedge sys_clk);
      rd(`CTM_OFS_MODE, 32'hd, "overflow flag");
      rd(`CTM_OFS_IRQ_STAT, 32'h7, "match and overflow status");
      wr(`CTM_OFS_MODE, 32'hc);
      rd(`CTM_OFS_MODE, 32'hc, "flag cleared after leaving zero");
      end_of_test();
   end
endmodule
